// ==== src/isrc_params.svh ====
`ifndef ISRC_PARAMS_SVH
`define ISRC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (4-bit address, 8-bit data)
// ----------------------------------------------------------------
`define ISRC_OFS_CTRL      4'h0
`define ISRC_OFS_FLAGS     4'h1
`define ISRC_OFS_TICK_IRQ  4'h2
`define ISRC_OFS_TIMER0    4'h3
`define ISRC_OFS_TIMER1    4'h4
`define ISRC_OFS_MONITOR   4'h5
`define ISRC_OFS_TBC       4'h6
`define ISRC_OFS_EVT_STAT  4'h7
`define ISRC_OFS_EVT_MASK  4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ISRC_CTRL_GLOBAL   0
`define ISRC_CTRL_OVP_EN   1
`define ISRC_CTRL_OCP_EN   2
`define ISRC_CTRL_CONV_EN  3
`define ISRC_CTRL_GRP_EN   4
`define ISRC_FLG_OVP       0
`define ISRC_FLG_OCP       1
`define ISRC_FLG_CONV      2
`define ISRC_FLG_GRP       3
`define ISRC_PAIR_FLAG_LO  4
`define ISRC_PAIR_EN_LO    0
`define ISRC_TBC_ON        7
`define ISRC_TBC_CKSEL     6
`define ISRC_TBC_T1_HI     5
`define ISRC_TBC_T1_LO     4
`define ISRC_TBC_T0_HI     2
`define ISRC_TBC_T0_LO     0
`define ISRC_EVT_TICK0     0
`define ISRC_EVT_TICK1     1
`define ISRC_EVT_SERVED    2
`define ISRC_EVT_STALLED   3

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define ISRC_TBC_RESET     8'h37
`define ISRC_TBC_MASK      8'hF7
`define ISRC_SYS_DIV       2'h3
`define ISRC_T0_BASE_LOG2  8
`define ISRC_T1_BASE_LOG2  12
`define ISRC_CNT_W         15

`endif

// ==== src/isrc_pkg.sv ====
package isrc_pkg;

	typedef enum logic [2:0] {
		VEC_OVP   = 3'b000,
		VEC_OCP   = 3'b001,
		VEC_GRP0  = 3'b010,
		VEC_GRP1  = 3'b011,
		VEC_CONV  = 3'b100,
		VEC_TICK0 = 3'b101,
		VEC_TICK1 = 3'b110,
		VEC_GRP2  = 3'b111
	} isrc_vec_t;

	typedef struct packed {
		logic overvoltage;
		logic overcurrent;
		logic conv_done;
		logic nvm_write_done;
		logic low_supply;
		logic [1:0] timer_period_match;
		logic [1:0] timer_a_match;
	} isrc_events_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} isrc_bus_t;

	typedef struct packed {
		logic global_irq_enable;
		logic ovp_en;
		logic ocp_en;
		logic conv_done_enable;
		logic [2:0] group_enable;
		logic overvoltage_req_flag;
		logic overcurrent_req_flag;
		logic conv_done_flag;
		logic [2:0] group_req_flag;
		logic [1:0] tick_req_flag;
		logic [1:0] tick_enable;
		logic [1:0] timer_period_match_flag;
		logic [1:0] timer_a_match_flag;
		logic [1:0] timer_period_match_enable;
		logic [1:0] timer_a_match_enable;
		logic nvm_write_done_flag;
		logic low_supply_flag;
		logic nvm_write_done_enable;
		logic low_supply_enable;
		logic [7:0] time_base_control;
		logic [14:0] tick_cnt;
		logic [1:0] sys_div;
		logic osc_s1;
		logic osc_s2;
		logic osc_s3;
		logic [3:0] evt_stat;
		logic [3:0] evt_mask;
		logic [7:0] rdata;
		logic req;
		isrc_vec_t vec;
	} isrc_state_t;

endpackage : isrc_pkg

// ==== src/isrc_ctrl.sv ====
// How it works
// - Over-voltage sets flag; vectors when enabled, room
// - Over-current sets flag; vectors when enabled, room
// - Protection service clears own flag and global
// - Group flag sets with any contained source
// - Group service clears group flag, global only
// - Conversion end sets flag; vectors when enabled
// - Conversion service clears its flag and global
// - Divider overflow sets tick flag; vectors enabled
// - Tick service clears its flag and global
// - Dividers run only while on bit set
// - Clock select: oscillator or system clock/4
// - Tick1 period 4096 to 32768, reset 11
// - Tick0 period 256 to 32768, reset 111
// - Write-done needs own and group2 enable
// - Low-supply needs own and group2 enable
// - Each timer: period and A match flags
// - Timer service clears only group flag, global
// - Flags, enables reset zero; unused bits zero
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "isrc_params.svh"

module isrc_ctrl (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register port
	input wire isrc_pkg::isrc_bus_t bus,
	output logic [7:0] rdata,
	// Source events, one-cycle pulses
	input wire isrc_pkg::isrc_events_t events,
	// Time-base oscillator clock pin
	input wire logic tick_osc_clk,
	// Program sequencer
	input wire logic stack_full,
	input wire logic irq_ack,
	output logic irq_req,
	output isrc_pkg::isrc_vec_t irq_vector,
	// Interrupt line
	output logic irq_line
);

	isrc_pkg::isrc_state_t st;
	isrc_pkg::isrc_state_t next_st;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Hardware set beats both a write and an auto clear
	function automatic logic upd(input logic cur, input logic wr,
			input logic wbit, input logic set, input logic clr);
		upd = set | (wr ? wbit : (cur & ~clr));
	endfunction : upd

	// Sticky bit cleared by writing one
	function automatic logic w1c(input logic cur, input logic wr,
			input logic wbit, input logic set);
		w1c = set | (cur & ~(wr & wbit));
	endfunction : w1c

	// Counter low bits all ones marks the end of a period
	function automatic logic period_end(input logic [14:0] cnt,
			input logic [3:0] log2);
		logic [14:0] lim;
		lim = 15'((32'h1 << log2) - 32'h1);
		period_end = ((cnt & lim) == lim);
	endfunction : period_end

	// Lowest pending code wins
	function automatic isrc_pkg::isrc_vec_t pick(input logic [7:0] p);
		isrc_pkg::isrc_vec_t v;
		v = isrc_pkg::VEC_GRP2;
		for (int i = 7; i >= 0; i--) begin
			if (p[i]) begin
				v = isrc_pkg::isrc_vec_t'(3'(i));
			end
		end
		pick = v;
	endfunction : pick

	// ------------------------------------------------------------
	// Combinational next state
	// ------------------------------------------------------------
	logic wr_ctrl;
	logic wr_flags;
	logic wr_tick;
	logic wr_mon;
	logic wr_tbc;
	logic wr_stat;
	logic wr_mask;
	logic [1:0] wr_tmr;
	logic [7:0] wd;
	logic ack;
	logic [7:0] clr;
	logic tick_step;
	logic [1:0] tick_ovf;
	logic [2:0] grp_set;
	logic [2:0] grp_src;
	logic [7:0] pending;
	logic any_pending;
	logic [3:0] t0_log2;
	logic [3:0] t1_log2;

	always_comb begin
		next_st = st;
		wd = bus.wdata;
		wr_ctrl = bus.wr && (bus.addr == `ISRC_OFS_CTRL);
		wr_flags = bus.wr && (bus.addr == `ISRC_OFS_FLAGS);
		wr_tick = bus.wr && (bus.addr == `ISRC_OFS_TICK_IRQ);
		wr_tmr[0] = bus.wr && (bus.addr == `ISRC_OFS_TIMER0);
		wr_tmr[1] = bus.wr && (bus.addr == `ISRC_OFS_TIMER1);
		wr_mon = bus.wr && (bus.addr == `ISRC_OFS_MONITOR);
		wr_tbc = bus.wr && (bus.addr == `ISRC_OFS_TBC);
		wr_stat = bus.wr && (bus.addr == `ISRC_OFS_EVT_STAT);
		wr_mask = bus.wr && (bus.addr == `ISRC_OFS_EVT_MASK);

		// Service acknowledge decodes the offered vector
		ack = irq_ack && st.req;
		clr = 8'h00;
		if (ack) begin
			clr[st.vec] = 1'b1;
		end

		// Time-base clock: synchronised oscillator edge or sys/4
		next_st.osc_s1 = tick_osc_clk;
		next_st.osc_s2 = st.osc_s1;
		next_st.osc_s3 = st.osc_s2;
		next_st.sys_div = st.sys_div + 2'h1;
		if (st.time_base_control[`ISRC_TBC_CKSEL]) begin
			tick_step = (st.sys_div == `ISRC_SYS_DIV);
		end else begin
			tick_step = st.osc_s2 & ~st.osc_s3;
		end

		// Dividers run only while on; cleared when off
		t0_log2 = 4'(`ISRC_T0_BASE_LOG2)
			+ {1'b0, st.time_base_control[`ISRC_TBC_T0_HI:`ISRC_TBC_T0_LO]};
		t1_log2 = 4'(`ISRC_T1_BASE_LOG2)
			+ {2'b00, st.time_base_control[`ISRC_TBC_T1_HI:`ISRC_TBC_T1_LO]};
		tick_ovf = 2'b00;
		if (!st.time_base_control[`ISRC_TBC_ON]) begin
			next_st.tick_cnt = '0;
		end else if (tick_step) begin
			next_st.tick_cnt = st.tick_cnt + 15'h0001;
			tick_ovf[0] = period_end(st.tick_cnt, t0_log2);
			tick_ovf[1] = period_end(st.tick_cnt, t1_log2);
		end

		// Control register
		if (wr_ctrl) begin
			next_st.ovp_en = wd[`ISRC_CTRL_OVP_EN];
			next_st.ocp_en = wd[`ISRC_CTRL_OCP_EN];
			next_st.conv_done_enable = wd[`ISRC_CTRL_CONV_EN];
			next_st.group_enable = wd[`ISRC_CTRL_GRP_EN +: 3];
		end
		// Any service drops the global enable
		next_st.global_irq_enable = wr_ctrl ? wd[`ISRC_CTRL_GLOBAL]
			: st.global_irq_enable;
		if (ack) begin
			next_st.global_irq_enable = 1'b0;
		end

		// Independent sources
		next_st.overvoltage_req_flag = upd(st.overvoltage_req_flag,
			wr_flags, wd[`ISRC_FLG_OVP], events.overvoltage,
			clr[isrc_pkg::VEC_OVP]);
		next_st.overcurrent_req_flag = upd(st.overcurrent_req_flag,
			wr_flags, wd[`ISRC_FLG_OCP], events.overcurrent,
			clr[isrc_pkg::VEC_OCP]);
		next_st.conv_done_flag = upd(st.conv_done_flag, wr_flags,
			wd[`ISRC_FLG_CONV], events.conv_done,
			clr[isrc_pkg::VEC_CONV]);

		// Tick flags and enables
		if (wr_tick) begin
			next_st.tick_enable = wd[`ISRC_PAIR_EN_LO +: 2];
		end
		next_st.tick_req_flag[0] = upd(st.tick_req_flag[0], wr_tick,
			wd[`ISRC_PAIR_FLAG_LO], tick_ovf[0],
			clr[isrc_pkg::VEC_TICK0]);
		next_st.tick_req_flag[1] = upd(st.tick_req_flag[1], wr_tick,
			wd[`ISRC_PAIR_FLAG_LO + 1], tick_ovf[1],
			clr[isrc_pkg::VEC_TICK1]);

		// Contained sources are never cleared by service
		for (int t = 0; t < 2; t++) begin
			if (wr_tmr[t]) begin
				next_st.timer_period_match_enable[t] =
					wd[`ISRC_PAIR_EN_LO];
				next_st.timer_a_match_enable[t] =
					wd[`ISRC_PAIR_EN_LO + 1];
			end
			next_st.timer_period_match_flag[t] =
				upd(st.timer_period_match_flag[t], wr_tmr[t],
				wd[`ISRC_PAIR_FLAG_LO],
				events.timer_period_match[t], 1'b0);
			next_st.timer_a_match_flag[t] =
				upd(st.timer_a_match_flag[t], wr_tmr[t],
				wd[`ISRC_PAIR_FLAG_LO + 1],
				events.timer_a_match[t], 1'b0);
		end
		if (wr_mon) begin
			next_st.low_supply_enable = wd[`ISRC_PAIR_EN_LO];
			next_st.nvm_write_done_enable = wd[`ISRC_PAIR_EN_LO + 1];
		end
		next_st.low_supply_flag = upd(st.low_supply_flag, wr_mon,
			wd[`ISRC_PAIR_FLAG_LO], events.low_supply,
			1'b0);
		next_st.nvm_write_done_flag = upd(st.nvm_write_done_flag,
			wr_mon, wd[`ISRC_PAIR_FLAG_LO + 1],
			events.nvm_write_done, 1'b0);

		// Group flags follow their contained sources
		grp_set[0] = events.timer_period_match[0]
			| events.timer_a_match[0];
		grp_set[1] = events.timer_period_match[1]
			| events.timer_a_match[1];
		grp_set[2] = events.nvm_write_done | events.low_supply;
		next_st.group_req_flag[0] = upd(st.group_req_flag[0],
			wr_flags, wd[`ISRC_FLG_GRP], grp_set[0],
			clr[isrc_pkg::VEC_GRP0]);
		next_st.group_req_flag[1] = upd(st.group_req_flag[1],
			wr_flags, wd[`ISRC_FLG_GRP + 1], grp_set[1],
			clr[isrc_pkg::VEC_GRP1]);
		next_st.group_req_flag[2] = upd(st.group_req_flag[2],
			wr_flags, wd[`ISRC_FLG_GRP + 2], grp_set[2],
			clr[isrc_pkg::VEC_GRP2]);

		// A group vectors only with an enabled contained source
		for (int g = 0; g < 2; g++) begin
			grp_src[g] = (st.timer_period_match_flag[g]
				& st.timer_period_match_enable[g])
				| (st.timer_a_match_flag[g]
				& st.timer_a_match_enable[g]);
		end
		grp_src[2] = (st.nvm_write_done_flag & st.nvm_write_done_enable)
			| (st.low_supply_flag & st.low_supply_enable);

		pending = 8'h00;
		pending[isrc_pkg::VEC_OVP] = st.overvoltage_req_flag
			& st.ovp_en;
		pending[isrc_pkg::VEC_OCP] = st.overcurrent_req_flag
			& st.ocp_en;
		pending[isrc_pkg::VEC_CONV] = st.conv_done_flag
			& st.conv_done_enable;
		pending[isrc_pkg::VEC_TICK0] = st.tick_req_flag[0]
			& st.tick_enable[0];
		pending[isrc_pkg::VEC_TICK1] = st.tick_req_flag[1]
			& st.tick_enable[1];
		pending[isrc_pkg::VEC_GRP0] = st.group_req_flag[0]
			& st.group_enable[0] & grp_src[0];
		pending[isrc_pkg::VEC_GRP1] = st.group_req_flag[1]
			& st.group_enable[1] & grp_src[1];
		pending[isrc_pkg::VEC_GRP2] = st.group_req_flag[2]
			& st.group_enable[2] & grp_src[2];
		if (ack) begin
			pending = pending & ~clr;
		end
		any_pending = |pending;

		// Offer to the sequencer; global enable and stack gate it
		next_st.req = any_pending && next_st.global_irq_enable
			&& !stack_full;
		next_st.vec = pick(pending);

		// Time-base control register
		if (wr_tbc) begin
			next_st.time_base_control = wd & `ISRC_TBC_MASK;
		end

		// Event status, mask and line
		if (wr_mask) begin
			next_st.evt_mask = wd[3:0];
		end
		next_st.evt_stat[`ISRC_EVT_TICK0] = w1c(
			st.evt_stat[`ISRC_EVT_TICK0], wr_stat,
			wd[`ISRC_EVT_TICK0], tick_ovf[0]);
		next_st.evt_stat[`ISRC_EVT_TICK1] = w1c(
			st.evt_stat[`ISRC_EVT_TICK1], wr_stat,
			wd[`ISRC_EVT_TICK1], tick_ovf[1]);
		next_st.evt_stat[`ISRC_EVT_SERVED] = w1c(
			st.evt_stat[`ISRC_EVT_SERVED], wr_stat,
			wd[`ISRC_EVT_SERVED], ack);
		next_st.evt_stat[`ISRC_EVT_STALLED] = w1c(
			st.evt_stat[`ISRC_EVT_STALLED], wr_stat,
			wd[`ISRC_EVT_STALLED], any_pending
			&& st.global_irq_enable && stack_full);

		// Read path, data in the following cycle
		next_st.rdata = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				`ISRC_OFS_CTRL: begin
					next_st.rdata = {1'b0, st.group_enable,
						st.conv_done_enable, st.ocp_en, st.ovp_en,
						st.global_irq_enable};
				end
				`ISRC_OFS_FLAGS: begin
					next_st.rdata = {2'b00, st.group_req_flag,
						st.conv_done_flag, st.overcurrent_req_flag,
						st.overvoltage_req_flag};
				end
				`ISRC_OFS_TICK_IRQ: begin
					next_st.rdata = {2'b00, st.tick_req_flag,
						2'b00, st.tick_enable};
				end
				`ISRC_OFS_TIMER0: begin
					next_st.rdata = {2'b00, st.timer_a_match_flag[0],
						st.timer_period_match_flag[0], 2'b00,
						st.timer_a_match_enable[0],
						st.timer_period_match_enable[0]};
				end
				`ISRC_OFS_TIMER1: begin
					next_st.rdata = {2'b00, st.timer_a_match_flag[1],
						st.timer_period_match_flag[1], 2'b00,
						st.timer_a_match_enable[1],
						st.timer_period_match_enable[1]};
				end
				`ISRC_OFS_MONITOR: begin
					next_st.rdata = {2'b00, st.nvm_write_done_flag,
						st.low_supply_flag, 2'b00,
						st.nvm_write_done_enable,
						st.low_supply_enable};
				end
				`ISRC_OFS_TBC: begin
					next_st.rdata = st.time_base_control;
				end
				`ISRC_OFS_EVT_STAT: begin
					next_st.rdata = {4'h0, st.evt_stat};
				end
				`ISRC_OFS_EVT_MASK: begin
					next_st.rdata = {4'h0, st.evt_mask};
				end
				default: begin
					next_st.rdata = 8'h00;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st <= '0;
			st.time_base_control <= `ISRC_TBC_RESET;
			st.vec <= isrc_pkg::VEC_OVP;
		end else begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	assign irq_req = st.req;
	assign irq_vector = st.vec;
	assign irq_line = |(st.evt_stat & st.evt_mask);

endmodule : isrc_ctrl

// ==== dv/isrc_ctrl_properties.sv ====
`timescale 1ns/1ps
module isrc_ctrl_checker (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register port
	input wire isrc_pkg::isrc_bus_t bus,
	input wire logic [7:0] rdata,
	// Sources and sequencer
	input wire isrc_pkg::isrc_events_t events,
	input wire logic tick_osc_clk,
	input wire logic stack_full,
	input wire logic irq_ack,
	input wire logic irq_req,
	input wire isrc_pkg::isrc_vec_t irq_vector,
	input wire logic irq_line
);
	logic glob;
	logic [3:0] msk;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// ----------
	// Shadow of global enable and event mask
	// ----------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			glob <= 1'b0;
			msk <= 4'h0;
		end else if (bus.wr && bus.addr == 4'h0) begin
			glob <= bus.wdata[0];
		end else if (bus.wr && bus.addr == 4'h8) begin
			msk <= bus.wdata[3:0];
		end else if (irq_ack && irq_req) begin
			glob <= 1'b0;
		end
	end

	// ----------
	// Properties
	// ----------
	AST_RESET_QUIET: assert property (
		$fell(rst) |-> !irq_req && !irq_line && rdata == 8'h00)
		else $error("outputs not quiet after reset");
	AST_RDATA_ONE_CYCLE: assert property (
		!$past(bus.rd) |-> rdata == 8'h00)
		else $error("read data outside its cycle");
	AST_UNMAPPED_ZERO: assert property (
		$past(bus.rd) && $past(bus.addr) > 4'h8 |-> rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_GLOBAL_GATES: assert property (
		irq_req |-> glob)
		else $error("request offered with global enable off");
	AST_ACK_DROPS: assert property (
		irq_ack && irq_req |=> !irq_req [*2])
		else $error("request stands after service");
	AST_FULL_BLOCKS: assert property (
		stack_full [*3] |-> !irq_req)
		else $error("request offered while stack full");
	AST_LINE_MASKED: assert property (
		irq_line |-> msk != 4'h0)
		else $error("interrupt line high with all masked");
	AST_MASK_READ: assert property (
		$past(bus.rd) && $past(bus.addr) == 4'h8 |->
			rdata == {4'h0, $past(msk)})
		else $error("mask readback wrong");
	AST_CTRL_READ: assert property (
		$past(bus.rd) && $past(bus.addr) == 4'h0 |->
			rdata[0] == $past(glob) && !rdata[7])
		else $error("global enable readback wrong");

	cover property (irq_ack && irq_req && irq_vector == isrc_pkg::VEC_GRP2);
	cover property (irq_ack && irq_req && irq_vector == isrc_pkg::VEC_TICK1);
	cover property (stack_full && glob && irq_line);
endmodule : isrc_ctrl_checker

bind isrc_ctrl isrc_ctrl_checker isrc_ctrl_checker_inst (
	.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata),
	.events(events), .tick_osc_clk(tick_osc_clk), .stack_full(stack_full),
	.irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector),
	.irq_line(irq_line));

// ==== dv/isrc_seq_model.sv ====
`timescale 1ns/1ps
module isrc_seq_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Bench controls
	input wire logic hold_full,
	input wire logic [1:0] ack_wait,
	// Sequencer side
	input wire logic irq_req,
	output logic stack_full = 1'b0,
	output logic irq_ack = 1'b0
);
	logic [1:0] cnt = 2'h0;

	// Slow fetch: ack after ack_wait plus one cycles of offer
	always @(posedge sys_clk) begin
		if (rst) begin
			stack_full <= 1'b0;
			irq_ack <= 1'b0;
			cnt <= 2'h0;
		end else begin
			stack_full <= hold_full;
			irq_ack <= 1'b0;
			if (irq_req && !irq_ack && !stack_full) begin
				cnt <= cnt + 2'h1;
				if (cnt == ack_wait) begin
					irq_ack <= 1'b1;
					cnt <= 2'h0;
				end
			end
		end
	end
endmodule : isrc_seq_model

// ==== dv/interrupt_sources_and_time_base_bench.sv ====
`timescale 1ns/1ps
module interrupt_sources_and_time_base_bench;
	logic sys_clk;
	logic rst;
	logic tick_osc_clk;
	logic hold_full;
	logic [1:0] ack_wait;
	logic stack_full;
	logic irq_ack;
	logic irq_req;
	logic irq_line;
	logic [7:0] rdata;
	logic rd_q = 1'b0;
	isrc_pkg::isrc_bus_t bus;
	isrc_pkg::isrc_events_t events;
	isrc_pkg::isrc_vec_t irq_vector;
	logic [7:0] exp_rd[$];
	logic [7:0] exp_vec[$];
	int mismatches = 0;
	int total_checks = 0;
	int served = 0;
	int want = 0;
	int cyc = 0;
	logic [7:0] msk[0:8] = '{8'h7F, 8'h3F, 8'h33, 8'h33, 8'h33,
		8'h33, 8'hF7, 8'h00, 8'h0F};
	logic [8:0] t_ev[0:6] = '{9'h100, 9'h080, 9'h040, 9'h004, 9'h002,
		9'h020, 9'h010};
	logic [7:0] t_ctl[0:6] = '{8'h03, 8'h05, 8'h09, 8'h11, 8'h21, 8'h41, 8'h41};
	logic [3:0] t_ena[0:6] = '{4'h5, 4'h5, 4'h5, 4'h3, 4'h4, 4'h5, 4'h5};
	logic [7:0] t_end[0:6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h02, 8'h01};
	logic [7:0] t_pst[0:6] = '{8'h00, 8'h00, 8'h00, 8'h11, 8'h22, 8'h22, 8'h11};
	logic [7:0] t_vec[0:6] = '{8'h00, 8'h01, 8'h04, 8'h02, 8'h03, 8'h07, 8'h07};

	isrc_ctrl isrc_ctrl_inst (
		.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata),
		.events(events), .tick_osc_clk(tick_osc_clk),
		.stack_full(stack_full), .irq_ack(irq_ack), .irq_req(irq_req),
		.irq_vector(irq_vector), .irq_line(irq_line));
	isrc_seq_model isrc_seq_model_inst (
		.sys_clk(sys_clk), .rst(rst), .hold_full(hold_full),
		.ack_wait(ack_wait), .irq_req(irq_req), .stack_full(stack_full),
		.irq_ack(irq_ack));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		tick_osc_clk = 1'b0;
		forever #100 tick_osc_clk = ~tick_osc_clk;
	end

	// ----------
	// Checking and bus tasks
	// ----------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic results();
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk);
		bus <= '0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_rd.push_back(e);
		@(posedge sys_clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge sys_clk);
		bus <= '0;
	endtask : rd

	task automatic pulse(input logic [8:0] e);
		@(posedge sys_clk);
		events <= e;
		@(posedge sys_clk);
		events <= '0;
	endtask : pulse

	task automatic serve(input logic [7:0] v, input int lim);
		int k;
		k = 0;
		exp_vec.push_back(v);
		want++;
		while (served < want && k < lim) begin
			@(posedge sys_clk);
			k++;
		end
		if (served < want) check(8'hEE, 8'h00);
		@(posedge sys_clk);
	endtask : serve

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		rd_q <= bus.rd;
		if (rd_q) begin
			check(rdata, exp_rd.size() > 0 ? exp_rd.pop_front() : 8'hXX);
		end
		if (irq_ack && irq_req) begin
			served++;
			check({5'h0, irq_vector},
				exp_vec.size() > 0 ? exp_vec.pop_front() : 8'hXX);
		end
	end

	initial begin
		repeat (40000) @(posedge sys_clk);
		mismatches++;
		results();
	end

	// ----------
	// Main sequence
	// ----------
	initial begin
		int i;
		int j;
		int t0;
		logic [7:0] d;
		rst = 1'b1;
		bus = '0;
		events = '0;
		hold_full = 1'b0;
		ack_wait = 2'h0;
		void'($urandom(32'h807FA3BF));
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		for (i = 0; i < 16; i++) rd(4'(i), i == 6 ? 8'h37 : 8'h00);
		hold_full <= 1'b1;
		for (i = 0; i < 9; i++) begin
			if (i != 7) begin
				d = 8'($urandom);
				wr(4'(i), d);
				rd(4'(i), d & msk[i]);
			end
		end
		wr(4'h6, 8'h00);
		for (i = 0; i < 9; i++) wr(4'(i), i == 7 ? 8'hFF : 8'h00);
		// Stalled by full stack, then the event line
		wr(4'h0, 8'h03);
		pulse(9'h100);
		repeat (4) @(posedge sys_clk);
		check({7'h0, irq_req}, 8'h00);
		rd(4'h1, 8'h01);
		rd(4'h7, 8'h08);
		wr(4'h8, 8'h08);
		@(negedge sys_clk);
		check({7'h0, irq_line}, 8'h01);
		wr(4'h8, 8'h00);
		@(negedge sys_clk);
		check({7'h0, irq_line}, 8'h00);
		@(posedge sys_clk);
		hold_full <= 1'b0;
		serve(8'h00, 20);
		rd(4'h0, 8'h02);
		rd(4'h1, 8'h00);
		wr(4'h8, 8'h0C);
		wr(4'h7, 8'h0C);
		@(negedge sys_clk);
		check({7'h0, irq_line}, 8'h00);
		// Seven event sources through their vectors
		for (j = 0; j < 7; j++) begin
			ack_wait <= 2'($urandom);
			for (i = 1; i < 6; i++) wr(4'(i), 8'h00);
			wr(t_ena[j], t_end[j]);
			wr(4'h0, t_ctl[j]);
			pulse(t_ev[j]);
			serve(t_vec[j], 20);
			rd(4'h0, t_ctl[j] & 8'hFE);
			rd(4'h1, 8'h00);
			rd(t_ena[j], t_pst[j]);
		end
		// Group enable gates the low-supply source
		wr(4'h5, 8'h01);
		wr(4'h0, 8'h01);
		pulse(9'h010);
		repeat (6) @(posedge sys_clk);
		check({7'h0, irq_req}, 8'h00);
		wr(4'h0, 8'h41);
		serve(8'h07, 20);
		// Simultaneous requests
		wr(4'h0, 8'h0F);
		pulse(9'h1C0);
		serve(8'h00, 20);
		wr(4'h0, 8'h0F);
		serve(8'h01, 20);
		wr(4'h0, 8'h0F);
		serve(8'h04, 20);
		// Time base from system clock over four
		wr(4'h2, 8'h01);
		wr(4'h0, 8'h01);
		wr(4'h6, 8'hC0);
		t0 = cyc;
		serve(8'h05, 1100);
		check({7'h0, cyc - t0 >= 1024 && cyc - t0 <= 1045}, 8'h01);
		rd(4'h2, 8'h01);
		wr(4'h2, 8'h02);
		wr(4'h0, 8'h01);
		serve(8'h06, 16000);
		check({7'h0, cyc - t0 >= 16384 && cyc - t0 <= 16410}, 8'h01);
		// Time base from the oscillator pin
		wr(4'h6, 8'h00);
		wr(4'h2, 8'h01);
		wr(4'h0, 8'h01);
		wr(4'h6, 8'h80);
		t0 = cyc;
		serve(8'h05, 2200);
		check({7'h0, cyc - t0 >= 2040 && cyc - t0 <= 2080}, 8'h01);
		wr(4'h6, 8'h40);
		wr(4'h2, 8'h00);
		repeat (1100) @(posedge sys_clk);
		rd(4'h2, 8'h00);
		repeat (2) @(posedge sys_clk);
		results();
	end
endmodule : interrupt_sources_and_time_base_bench
